// *** core_clk_sel.sv ***
// glitchless per-core source and divider selector
module core_clk_sel (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [clk_ctrl_pkg::N_PLL-1:0] pll_tick,
    core_cfg_if.sel cfg
);
    clk_ctrl_pkg::src_t src_r, src_nxt;
    clk_ctrl_pkg::sel_state_t state_r, state_nxt;
    logic div_pll_r, div_pll_nxt;
    logic div_ratio_r, div_ratio_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    logic src_tick;
    logic [1:0] last;
    logic change;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        src_nxt = src_r;
        div_pll_nxt = div_pll_r;
        div_ratio_nxt = div_ratio_r;
        cnt_nxt = cnt_r;
        state_nxt = state_r;
        tick_nxt = 1'b0;
        case (src_r)
            clk_ctrl_pkg::SRC_PLL_A: begin
                src_tick = pll_tick[clk_ctrl_pkg::PLL_A_IDX];
            end
            clk_ctrl_pkg::SRC_PLL_B: begin
                src_tick = pll_tick[clk_ctrl_pkg::PLL_B_IDX];
            end
            clk_ctrl_pkg::SRC_DIV: begin
                src_tick = div_pll_r ? pll_tick[clk_ctrl_pkg::DIV_PLL_HI_IDX]
                                     : pll_tick[clk_ctrl_pkg::DIV_PLL_LO_IDX];
            end
            default: begin
                src_tick = 1'b0;
            end
        endcase
        last = div_ratio_r ? clk_ctrl_pkg::DIV4_LAST
                           : clk_ctrl_pkg::DIV2_LAST;
        if (src_r == clk_ctrl_pkg::SRC_DIV) begin
            if (src_tick) begin
                if (cnt_r == last) begin
                    cnt_nxt = clk_ctrl_pkg::CNT_RST;
                    tick_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 2'h1;
                end
            end
        end else begin
            tick_nxt = src_tick;
        end
        change = (cfg.src != src_r) || (cfg.div_pll != div_pll_r) ||
                 (cfg.div_ratio != div_ratio_r);
        case (state_r)
            clk_ctrl_pkg::SEL_RUN: begin
                if (change) begin
                    state_nxt = clk_ctrl_pkg::SEL_SWITCH;
                end
            end
            clk_ctrl_pkg::SEL_SWITCH: begin
                // hand over only once the running cycle has completed
                if (tick_nxt) begin
                    src_nxt = cfg.src;
                    div_pll_nxt = cfg.div_pll;
                    div_ratio_nxt = cfg.div_ratio;
                    cnt_nxt = clk_ctrl_pkg::CNT_RST;
                    state_nxt = clk_ctrl_pkg::SEL_RUN;
                end
            end
            default: begin
                state_nxt = clk_ctrl_pkg::SEL_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_r <= clk_ctrl_pkg::RST_SRC;
            div_pll_r <= clk_ctrl_pkg::RST_DIV_PLL;
            div_ratio_r <= clk_ctrl_pkg::RST_DIV_RATIO;
            cnt_r <= clk_ctrl_pkg::CNT_RST;
            state_r <= clk_ctrl_pkg::SEL_RUN;
            tick_r <= 1'b0;
        end else begin
            src_r <= src_nxt;
            div_pll_r <= div_pll_nxt;
            div_ratio_r <= div_ratio_nxt;
            cnt_r <= cnt_nxt;
            state_r <= state_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign cfg.tick = tick_r;
    assign cfg.busy = (state_r == clk_ctrl_pkg::SEL_SWITCH);
endmodule

// *** clk_ctrl_pkg.sv ***
// constants and types shared by the clock control block
package clk_ctrl_pkg;
    typedef enum logic [1:0] {
        SRC_PLL_A = 2'h0,
        SRC_PLL_B = 2'h1,
        SRC_DIV = 2'h2
    } src_t;

    typedef enum logic [0:0] {
        SEL_RUN = 1'h0,
        SEL_SWITCH = 1'h1
    } sel_state_t;

    localparam int N_PLL = 3;
    localparam int PLL_A_IDX = 0;
    localparam int PLL_B_IDX = 1;
    localparam int DIV_PLL_LO_IDX = 1;
    localparam int DIV_PLL_HI_IDX = 2;
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam src_t RST_SRC = SRC_PLL_A;
    localparam logic RST_DIV_PLL = 1'h0;
    localparam logic RST_DIV_RATIO = 1'h0;
    localparam logic RST_DIS = 1'h0;
    localparam logic RST_ACT = 1'h0;
endpackage

// *** core_cfg_if.sv ***
// per-core clock selection carrier between controller and selector
interface core_cfg_if;
    clk_ctrl_pkg::src_t src;
    logic div_pll;
    logic div_ratio;
    logic tick;
    logic busy;

    modport ctrl (output src, output div_pll, output div_ratio,
                  input tick, input busy);
    modport sel (input src, input div_pll, input div_ratio,
                 output tick, output busy);
endinterface

// *** soc_clock_gating_and_select.sv ***
// clock gating, device disable and per-core clock selection
module soc_clock_gating_and_select #(
    parameter int N_CORE = 4,
    parameter int N_BLK = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [clk_ctrl_pkg::N_PLL-1:0] pll_tick,
    input wire logic [N_BLK-1:0] work_dispatch,
    input wire logic [N_BLK-1:0] blk_busy,
    input wire logic [N_BLK-1:0] device_disable_ctrl,
    output logic [N_BLK-1:0] blk_clk_en,
    output logic [N_BLK-1:0] blk_disabled,
    input wire logic [1:0] core_src_sel [N_CORE],
    input wire logic [N_CORE-1:0] core_div_pll,
    input wire logic [N_CORE-1:0] core_div_ratio,
    output logic [N_CORE-1:0] core_clk_tick,
    output logic [N_CORE-1:0] core_switching
);
    logic [N_BLK-1:0] act_r, act_nxt;
    logic [N_BLK-1:0] dis_r, dis_nxt;
    clk_ctrl_pkg::src_t src_r [N_CORE];
    clk_ctrl_pkg::src_t src_nxt [N_CORE];
    logic [N_CORE-1:0] div_pll_r, div_pll_nxt;
    logic [N_CORE-1:0] div_ratio_r, div_ratio_nxt;

    function automatic logic src_code_ok(input logic [1:0] code);
        src_code_ok = (code == clk_ctrl_pkg::SRC_PLL_A) ||
                      (code == clk_ctrl_pkg::SRC_PLL_B) ||
                      (code == clk_ctrl_pkg::SRC_DIV);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // block gating and static disable
    always_comb begin
        dis_nxt = dis_r | device_disable_ctrl;
        act_nxt = (work_dispatch | blk_busy) & ~dis_nxt;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dis_r <= {N_BLK{clk_ctrl_pkg::RST_DIS}};
            act_r <= {N_BLK{clk_ctrl_pkg::RST_ACT}};
        end else begin
            dis_r <= dis_nxt;
            act_r <= act_nxt;
        end
    end

    assign blk_clk_en = act_r;
    assign blk_disabled = dis_r;

    ////////////////////////////////////////////////////////////////////////
    // core clock selection requests; unused source code is ignored
    always_comb begin
        div_pll_nxt = core_div_pll;
        div_ratio_nxt = core_div_ratio;
        for (int c = 0; c < N_CORE; c++) begin
            src_nxt[c] = src_r[c];
            if (src_code_ok(core_src_sel[c])) begin
                src_nxt[c] = clk_ctrl_pkg::src_t'(core_src_sel[c]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int c = 0; c < N_CORE; c++) begin
                src_r[c] <= clk_ctrl_pkg::RST_SRC;
            end
            div_pll_r <= {N_CORE{clk_ctrl_pkg::RST_DIV_PLL}};
            div_ratio_r <= {N_CORE{clk_ctrl_pkg::RST_DIV_RATIO}};
        end else begin
            for (int c = 0; c < N_CORE; c++) begin
                src_r[c] <= src_nxt[c];
            end
            div_pll_r <= div_pll_nxt;
            div_ratio_r <= div_ratio_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one glitchless selector per core
    for (genvar g = 0; g < N_CORE; g++) begin : g_core
        core_cfg_if cfg ();

        assign cfg.src = src_r[g];
        assign cfg.div_pll = div_pll_r[g];
        assign cfg.div_ratio = div_ratio_r[g];
        assign core_clk_tick[g] = cfg.tick;
        assign core_switching[g] = cfg.busy;

        core_clk_sel u_sel (
            .core_clk(core_clk),
            .reset(reset),
            .pll_tick(pll_tick),
            .cfg(cfg)
        );
    end
endmodule

// *** soc_clock_gating_and_select_sva.sv ***
// assertion checker for the clock control block
module soc_clock_gating_and_select_sva #(
    parameter int N_CORE = 4,
    parameter int N_BLK = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [clk_ctrl_pkg::N_PLL-1:0] pll_tick,
    input wire logic [N_BLK-1:0] work_dispatch,
    input wire logic [N_BLK-1:0] blk_busy,
    input wire logic [N_BLK-1:0] device_disable_ctrl,
    input wire logic [N_BLK-1:0] blk_clk_en,
    input wire logic [N_BLK-1:0] blk_disabled,
    input wire logic [N_CORE-1:0] core_clk_tick,
    input wire logic [N_CORE-1:0] core_switching
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_fresh;
        $past(reset);
    endsequence
    sequence s_settled;
        !$past(reset);
    endsequence
    sequence s_handover;
        $fell(core_switching[0]);
    endsequence
    AST_GATE_ON: assert property (s_settled |->
        blk_clk_en == ($past(work_dispatch | blk_busy)
        & ~$past(device_disable_ctrl) & ~$past(blk_disabled)))
        else $error("gate enable wrong");
    AST_IDLE: assert property (s_settled
        and $past((work_dispatch | blk_busy) == 0) |-> blk_clk_en == 0)
        else $error("idle block clock on");
    AST_DIS_SET: assert property (s_settled |->
        (blk_disabled & $past(device_disable_ctrl))
        == $past(device_disable_ctrl)) else $error("disable missed");
    AST_DIS_KEEP: assert property (s_settled |->
        ($past(blk_disabled) & ~blk_disabled) == 0)
        else $error("disable cleared");
    AST_DIS_OFF: assert property ((blk_clk_en & blk_disabled) == 0)
        else $error("disabled block clocked");
    AST_RST: assert property (s_fresh |-> blk_clk_en == 0
        && blk_disabled == 0 && core_switching == 0)
        else $error("reset state wrong");
    AST_TICK: assert property (s_settled
        and core_clk_tick != 0 |-> $past(pll_tick) != 0)
        else $error("tick without source");
    AST_HANDOVER: assert property (s_handover |-> core_clk_tick[0])
        else $error("switch without cycle end");
endmodule
bind soc_clock_gating_and_select soc_clock_gating_and_select_sva #(
    .N_CORE(N_CORE), .N_BLK(N_BLK)) i_sva (.core_clk(core_clk),
    .reset(reset), .pll_tick(pll_tick), .work_dispatch(work_dispatch),
    .blk_busy(blk_busy), .device_disable_ctrl(device_disable_ctrl),
    .blk_clk_en(blk_clk_en), .blk_disabled(blk_disabled),
    .core_clk_tick(core_clk_tick), .core_switching(core_switching));

// *** blk_model.sv ***
// peripheral block model: busy until it sees one clocked cycle
module blk_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] work_dispatch,
    input wire logic [7:0] blk_clk_en,
    output logic [7:0] blk_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] busy_nxt;
    always_comb begin
        busy_nxt = reset ? 8'h00 : work_dispatch | blk_busy & ~blk_clk_en;
    end
    always_ff @(posedge core_clk) blk_busy <= busy_nxt;
endmodule

// *** tb_soc_clock_gating_and_select.sv ***
// self-checking bench for the clock control block
module tb_soc_clock_gating_and_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1;
    logic [2:0] pll_tick = 0;
    logic [7:0] wd = 0, dis = 0, en, blk_dis, busy;
    logic [1:0] sel [4] = '{default: 0};
    logic [3:0] dpll = 0, drat = 0, tick, sw;
    int errors = 0, n_compared = 0, ph = 0;
    int cnt [4];
    // src, divider pll, ratio, ticks in 48 cycles, switching; A/2 B/3 C/4
    int rows [7][5] = '{'{0,0,0,24,0}, '{1,0,0,16,1}, '{2,0,0,8,1},
        '{2,0,1,4,1}, '{2,1,0,6,1}, '{2,1,1,3,1}, '{3,1,1,3,0}};
    soc_clock_gating_and_select i_soc_clock_gating_and_select (
        .core_clk(core_clk), .reset(reset), .pll_tick(pll_tick),
        .work_dispatch(wd), .blk_busy(busy), .device_disable_ctrl(dis),
        .blk_clk_en(en), .blk_disabled(blk_dis), .core_src_sel(sel),
        .core_div_pll(dpll), .core_div_ratio(drat),
        .core_clk_tick(tick), .core_switching(sw));
    blk_model i_blk_model (.core_clk(core_clk), .reset(reset),
        .work_dispatch(wd), .blk_clk_en(en), .blk_busy(busy));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test();
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        #1;
        pll_tick <= {ph % 4 == 0, ph % 3 == 0, ph % 2 == 0};
        ph++;
    end
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
    initial begin
        step(8);
        reset = 0;
        step(1);
        chk("rst", {en, blk_dis, sw}, 0);
        foreach (rows[r]) begin
            foreach (sel[c]) sel[c] = 2'(rows[r][0]);
            dpll = {4{rows[r][1] == 1}};
            drat = {4{rows[r][2] == 1}};
            step(2);
            chk("sw", sw, {4{rows[r][4] == 1}});
            step(1);
            for (int k = 0; k < 100 && sw != 0; k++) step(1);
            chk("sw", sw, 0);
            cnt = '{default: 0};
            repeat (48) begin
                step(1);
                foreach (cnt[c]) cnt[c] += tick[c];
            end
            foreach (cnt[c]) chk("ticks", cnt[c], rows[r][3]);
        end
        wd = 8'hFF;
        step(1);
        wd = 0;
        chk("en", en, 8'hFF);
        step(3);
        chk("en", en, 0);
        dis = 8'h04;
        step(1);
        dis = 0;
        wd = 8'hFF;
        step(1);
        chk("dis", blk_dis, 8'h04);
        chk("en", en, 8'hFB);
        wd = 0;
        reset = 1;
        step(2);
        reset = 0;
        step(1);
        wd = 8'h04;
        step(1);
        chk("en", en, 8'h04);
        end_of_test();
    end
endmodule
